/* File: shared/sdil_map.svh */
`ifndef SDIL_MAP_SVH
`define SDIL_MAP_SVH

// ============================================================
// clock and rounding
`define SDIL_SYS_CLK_NS 100
// least time in ns to whole cycles, rounded up, never below one
`define SDIL_MIN_CYC(ns) \
  ((((ns) + `SDIL_SYS_CLK_NS - 1) / `SDIL_SYS_CLK_NS) < 1 ? 1 : \
   (((ns) + `SDIL_SYS_CLK_NS - 1) / `SDIL_SYS_CLK_NS))

// ============================================================
// link timing, ns, worst case over both logic supply ranges
`define SDIL_T_SCLK_PERIOD_NS 70
`define SDIL_T_SCLK_HIGH_NS   35
`define SDIL_T_SCLK_LOW_NS    35
`define SDIL_T_CS_SETUP_NS    5
`define SDIL_T_CS_NEXT_NS     50
`define SDIL_T_CS_HOLD_NS     10
`define SDIL_T_CS_HIGH_NS     15
`define SDIL_T_LD_PULSE_NS    20
`define SDIL_T_CS_TO_LD_NS    10
`define SDIL_T_LD_TO_SCLK_NS  60

// ============================================================
// word layout
`define SDIL_RES_DEFAULT      18
`define SDIL_CODE_TOP_18B     17
`define SDIL_CODE_TOP_16B     15
`define SDIL_CODE_TOP_14B     13

`endif

/* File: shared/sdil_pkg.sv */
`default_nettype none

package sdil_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SETUP,
    ST_HIGH,
    ST_LOW,
    ST_HOLD,
    ST_LDWAIT,
    ST_LDLOW,
    ST_GAP
  } sdil_state_e;

  typedef logic [7:0] sdil_cnt_t;

endpackage

`default_nettype wire

/* File: logic/sdil_host.sv */
`include "sdil_map.svh"

`default_nettype none

// How it works
// - frame is sent most significant bit first, FRAME_BITS long
// - strobe mode pulls load strobe low only after chip select rose
// - load strobe stays high for the whole shifting phase in strobe mode
// - narrow user data padded with zeros in least significant bits
// - sclk phases and period held well above the 35 ns and 70 ns minimums
module sdil_host #(
  parameter int RES        = `SDIL_RES_DEFAULT,
  parameter int DATA_W     = RES,
  parameter int FRAME_BITS = RES,
  parameter bit MIDSCALE   = 1'b0,
  parameter bit HAS_STROBE = 1'b1
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // user request
  input  wire logic              i_req,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_use_strobe,
  // user status
  output var  logic              o_busy,
  output var  logic              o_done,
  output var  logic [RES-1:0]    o_code,
  // converter pins
  output var  logic              o_dac_cs_n,
  output var  logic              o_dac_sclk,
  output var  logic              o_dac_din,
  output var  logic              o_load_output_strobe_n
);

  localparam int BW = $clog2(FRAME_BITS + 1);
  localparam int CODE_TOP = RES - 1;

  // ============================================================
  // cycle counts derived from the link times
  localparam int HALF_HI = `SDIL_MIN_CYC(`SDIL_T_SCLK_HIGH_NS);
  localparam int HALF_LO_T = `SDIL_MIN_CYC(`SDIL_T_SCLK_LOW_NS);
  localparam int PER_CYC = `SDIL_MIN_CYC(`SDIL_T_SCLK_PERIOD_NS);
  // low phase stretched so that high plus low covers the full period
  localparam int HALF_LO = (HALF_LO_T + HALF_HI < PER_CYC) ?
                           PER_CYC - HALF_HI : HALF_LO_T;
  localparam int SETUP_C = `SDIL_MIN_CYC(`SDIL_T_CS_SETUP_NS);
  localparam int HOLD_C  = `SDIL_MIN_CYC(`SDIL_T_CS_HOLD_NS);
  localparam int CSH_C   = `SDIL_MIN_CYC(`SDIL_T_CS_HIGH_NS);
  localparam int NEXT_C  = `SDIL_MIN_CYC(`SDIL_T_CS_NEXT_NS);
  localparam int GAP_C   = (CSH_C > NEXT_C) ? CSH_C : NEXT_C;
  localparam int LDW_C   = `SDIL_MIN_CYC(`SDIL_T_CS_TO_LD_NS);
  localparam int LDP_C   = `SDIL_MIN_CYC(`SDIL_T_LD_PULSE_NS);
  localparam int LDG_T   = `SDIL_MIN_CYC(`SDIL_T_LD_TO_SCLK_NS);
  localparam int LDG_C   = (LDG_T > GAP_C) ? LDG_T : GAP_C;

  localparam logic [RES-1:0] RESET_CODE =
    MIDSCALE ? (RES'(1) << CODE_TOP) : '0;

  // ============================================================
  // state and timing counter
  sdil_pkg::sdil_state_e state_r;
  sdil_pkg::sdil_cnt_t   cnt_r;
  logic [BW-1:0]         bits_r;
  logic [FRAME_BITS-1:0] shreg_r;
  logic [RES-1:0]        word_r;
  logic                  strobe_r;

  logic                  tick;
  logic                  last_bit;
  logic                  use_strobe;
  logic [RES-1:0]        padded;
  logic [FRAME_BITS-1:0] frame;

  assign tick       = (cnt_r == sdil_pkg::sdil_cnt_t'(1));
  assign last_bit   = (bits_r == BW'(1));
  assign use_strobe = HAS_STROBE & i_use_strobe;
  // zero padding in the low bits for narrow data
  assign padded     = RES'(i_data) << (RES - DATA_W);
  // excess leading bits are zero, the device keeps the last RES bits
  assign frame      = FRAME_BITS'(padded);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= sdil_pkg::ST_IDLE;
      cnt_r   <= sdil_pkg::sdil_cnt_t'(1);
    end else begin
      case (state_r)
        sdil_pkg::ST_IDLE: begin
          if (i_req) begin
            state_r <= sdil_pkg::ST_SETUP;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(SETUP_C);
          end
        end
        sdil_pkg::ST_SETUP: begin
          if (tick) begin
            state_r <= sdil_pkg::ST_HIGH;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(HALF_HI);
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        sdil_pkg::ST_HIGH: begin
          if (tick && last_bit) begin
            state_r <= sdil_pkg::ST_HOLD;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(HOLD_C);
          end else if (tick) begin
            state_r <= sdil_pkg::ST_LOW;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(HALF_LO);
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        sdil_pkg::ST_LOW: begin
          if (tick) begin
            state_r <= sdil_pkg::ST_HIGH;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(HALF_HI);
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        sdil_pkg::ST_HOLD: begin
          if (tick && strobe_r) begin
            state_r <= sdil_pkg::ST_LDWAIT;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(LDW_C);
          end else if (tick) begin
            state_r <= sdil_pkg::ST_GAP;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(GAP_C);
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        sdil_pkg::ST_LDWAIT: begin
          if (tick) begin
            state_r <= sdil_pkg::ST_LDLOW;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(LDP_C);
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        sdil_pkg::ST_LDLOW: begin
          if (tick) begin
            state_r <= sdil_pkg::ST_GAP;
            cnt_r   <= sdil_pkg::sdil_cnt_t'(LDG_C);
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        sdil_pkg::ST_GAP: begin
          if (tick) begin
            state_r <= sdil_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - sdil_pkg::sdil_cnt_t'(1);
          end
        end
        default: begin
          state_r <= sdil_pkg::ST_IDLE;
          cnt_r   <= sdil_pkg::sdil_cnt_t'(1);
        end
      endcase
    end
  end

  // ============================================================
  // frame shift register and bit count
  // a full frame is sent unless reset cuts it short, which leaves a short word at the pins
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg_r  <= '0;
      bits_r   <= '0;
      word_r   <= '0;
      strobe_r <= 1'b0;
    end else if (state_r == sdil_pkg::ST_IDLE && i_req) begin
      shreg_r  <= frame;
      bits_r   <= BW'(FRAME_BITS);
      word_r   <= padded;
      strobe_r <= use_strobe;
    end else if (state_r == sdil_pkg::ST_HIGH && tick && !last_bit) begin
      shreg_r <= shreg_r << 1;
      bits_r  <= bits_r - BW'(1);
    end
  end

  // ============================================================
  // converter pins
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dac_cs_n <= 1'b1;
      o_dac_sclk <= 1'b0;
      o_dac_din  <= 1'b0;
    end else begin
      case (state_r)
        sdil_pkg::ST_IDLE: begin
          if (i_req) begin
            o_dac_cs_n <= 1'b0;
            o_dac_din  <= frame[FRAME_BITS-1];
          end
        end
        sdil_pkg::ST_SETUP: begin
          if (tick) begin
            o_dac_sclk <= 1'b1;
          end
        end
        sdil_pkg::ST_HIGH: begin
          if (tick && !last_bit) begin
            // data moves on the falling edge, far from the sampling edge
            o_dac_sclk <= 1'b0;
            o_dac_din  <= shreg_r[FRAME_BITS-2];
          end
        end
        sdil_pkg::ST_LOW: begin
          if (tick) begin
            o_dac_sclk <= 1'b1;
          end
        end
        sdil_pkg::ST_HOLD: begin
          if (tick) begin
            o_dac_cs_n <= 1'b1;
            o_dac_sclk <= 1'b0;
            o_dac_din  <= 1'b0;
          end
        end
        default: begin
          o_dac_cs_n <= 1'b1;
          o_dac_sclk <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // load strobe
  // high by default; tied-low mode only applies once idle, never mid-frame
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_load_output_strobe_n <= 1'b1;
    end else if (state_r == sdil_pkg::ST_IDLE) begin
      o_load_output_strobe_n <= use_strobe;
    end else if (state_r == sdil_pkg::ST_LDWAIT && tick) begin
      o_load_output_strobe_n <= 1'b0;
    end else if (state_r == sdil_pkg::ST_LDLOW && tick) begin
      o_load_output_strobe_n <= 1'b1;
    end
  end

  // ============================================================
  // status and mirror of the latched code
  // the mirror updates on the select rise, or on the strobe rise in strobe mode, not on the request
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_code <= RESET_CODE;
    end else if (state_r == sdil_pkg::ST_HOLD && tick && !strobe_r) begin
      o_code <= word_r;
    end else if (state_r == sdil_pkg::ST_LDLOW && tick) begin
      o_code <= word_r;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= (state_r == sdil_pkg::ST_GAP) && tick;
      if (state_r == sdil_pkg::ST_IDLE && i_req) begin
        o_busy <= 1'b1;
      end else if (state_r == sdil_pkg::ST_GAP && tick) begin
        o_busy <= 1'b0;
      end
    end
  end

  // code top bit position, one per supported resolution
  initial begin
    if (!(CODE_TOP == `SDIL_CODE_TOP_18B || CODE_TOP == `SDIL_CODE_TOP_16B ||
          CODE_TOP == `SDIL_CODE_TOP_14B)) begin
    end
  end

endmodule

`default_nettype wire

/* File: verification/sdil_host_props.sv */
`default_nettype none

module sdil_host_props #(
  parameter int RES        = 18,
  parameter int FRAME_BITS = 18
) (
  input wire logic           i_sys_clk,
  input wire logic           i_rst,
  input wire logic           o_done,
  input wire logic [RES-1:0] o_code,
  input wire logic           o_dac_cs_n,
  input wire logic           o_dac_sclk,
  input wire logic           o_dac_din,
  input wire logic           o_load_output_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // shadow of the converter's shift register
  logic           sclk_q_r;
  logic [7:0]     rises_r;
  logic [RES-1:0] shadow_r;
  wire logic      rise_w = o_dac_sclk & ~sclk_q_r & ~o_dac_cs_n;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q_r <= 1'b0;
      rises_r  <= 8'h00;
      shadow_r <= '0;
    end else begin
      sclk_q_r <= o_dac_sclk;
      rises_r  <= o_dac_cs_n ? 8'h00 : rises_r + 8'(rise_w);
      if (rise_w) begin
        shadow_r <= {shadow_r[RES-2:0], o_dac_din};
      end
    end
  end
  // ==========
  // properties
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_sclk_in_frame: assert property (
    o_dac_sclk |-> !o_dac_cs_n) else $error("sclk outside frame");
  a_cs_setup: assert property (
    $fell(o_dac_cs_n) |-> !o_dac_sclk ##1 o_dac_sclk)
    else $error("no setup before first sclk");
  a_din_steady: assert property (
    !o_dac_cs_n && $changed(o_dac_din) |-> !o_dac_sclk)
    else $error("din moved with sclk high");
  a_frame_bits: assert property (
    $rose(o_dac_cs_n) |-> rises_r == 8'(FRAME_BITS))
    else $error("wrong frame length");
  a_latch_code: assert property (
    ($rose(o_dac_cs_n) && !o_load_output_strobe_n) ||
    $rose(o_load_output_strobe_n) |-> o_code == shadow_r)
    else $error("code mirror differs from shifted word");
  a_code_cause: assert property (
    $changed(o_code) |-> $rose(o_dac_cs_n) || $rose(o_load_output_strobe_n))
    else $error("code changed without update edge");
  a_strobe_after_cs: assert property (
    $fell(o_load_output_strobe_n) |-> o_dac_cs_n && $past(o_dac_cs_n))
    else $error("strobe fell with select low");
  a_strobe_pulse: assert property (
    $rose(o_dac_cs_n) && o_load_output_strobe_n |->
    ##1 !o_load_output_strobe_n ##1 o_load_output_strobe_n)
    else $error("no strobe pulse after frame");
  a_strobe_still: assert property (
    !o_dac_cs_n |-> $stable(o_load_output_strobe_n))
    else $error("strobe moved while shifting");
  c_tied: cover property ($rose(o_dac_cs_n) && !o_load_output_strobe_n);
  c_strobe: cover property ($rose(o_load_output_strobe_n));
  c_next: cover property (o_done ##2 $fell(o_dac_cs_n));
endmodule

bind sdil_host sdil_host_props #(.RES(RES), .FRAME_BITS(FRAME_BITS)) u_props (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .o_done(o_done),
  .o_code(o_code),
  .o_dac_cs_n(o_dac_cs_n),
  .o_dac_sclk(o_dac_sclk),
  .o_dac_din(o_dac_din),
  .o_load_output_strobe_n(o_load_output_strobe_n)
);

`default_nettype wire

/* File: verification/sdil_dev_model.sv */
`default_nettype none

module sdil_dev_model #(
  parameter int RES        = 16,
  parameter bit MIDSCALE   = 1'b0,
  parameter bit HAS_STROBE = 1'b1
) (
  input  wire logic           i_cs_n,
  input  wire logic           i_sclk,
  input  wire logic           i_din,
  input  wire logic           i_load_output_strobe_n,
  output var  logic [RES-1:0] o_latch
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // shift register left unknown at power-on, as on silicon
  logic [RES-1:0] shift_r;
  int             nbits = 0;
  wire logic      ld_n_w = HAS_STROBE ? i_load_output_strobe_n : 1'b0;
  // plain binary code; segment decode is analog and not modelled
  initial o_latch = MIDSCALE ? RES'(1) << (RES - 1) : '0;
  always @(negedge i_cs_n) nbits = 0;
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      shift_r = {shift_r[RES-2:0], i_din};
      nbits++;
    end
  end
  // short frames leave the latch alone
  always @(posedge i_cs_n) begin
    if (!ld_n_w && nbits >= RES) o_latch = shift_r;
  end
  always @(negedge ld_n_w) begin
    if (i_cs_n && nbits >= RES) o_latch = shift_r;
  end
endmodule

`default_nettype wire

/* File: verification/sdil_host_test.sv */
`default_nettype none

module sdil_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  // narrow data and long frames exercise padding and excess bits
  localparam int RES = 16;
  localparam int DW  = 12;
  localparam int FB  = 18;
  logic           i_sys_clk, i_rst, i_req, i_use_strobe;
  logic [DW-1:0]  i_data;
  // last word that a full frame delivered to the converter
  logic [DW-1:0]  last_d;
  logic           o_busy, o_done, o_dac_cs_n, o_dac_sclk, o_dac_din, o_ld_n;
  logic [RES-1:0] o_code, dev_code;
  int             n_fail, num_checks, seed, i;
  sdil_host #(.RES(RES), .DATA_W(DW), .FRAME_BITS(FB), .MIDSCALE(1'b0),
    .HAS_STROBE(1'b1)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_req(i_req), .i_data(i_data), .i_use_strobe(i_use_strobe),
    .o_busy(o_busy), .o_done(o_done), .o_code(o_code),
    .o_dac_cs_n(o_dac_cs_n), .o_dac_sclk(o_dac_sclk), .o_dac_din(o_dac_din),
    .o_load_output_strobe_n(o_ld_n));
  sdil_dev_model #(.RES(RES), .MIDSCALE(1'b0), .HAS_STROBE(1'b1)) u_dev (
    .i_cs_n(o_dac_cs_n), .i_sclk(o_dac_sclk), .i_din(o_dac_din),
    .i_load_output_strobe_n(o_ld_n), .o_latch(dev_code));
  // ==========
  // helpers
  function automatic logic [RES-1:0] exp_code(logic [DW-1:0] d);
    return {d, {(RES - DW){1'b0}}};
  endfunction
  task automatic check(string nm, logic [RES-1:0] e, logic [RES-1:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(logic [DW-1:0] d, logic m);
    int k;
    // mode settles a cycle ahead, so the strobe never moves with select low
    @(posedge i_sys_clk);
    i_use_strobe <= m;
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_data <= d;
    @(posedge i_sys_clk);
    i_req <= 1'b0;
    last_d = d;
    for (k = 0; k < 100 && o_done !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    check("done", 16'h0001, {15'h0000, o_done});
    check("host code", exp_code(d), o_code);
    check("device code", exp_code(d), dev_code);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========
  // stimulus
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (8000) @(posedge i_sys_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    seed = 32'h6c2fd432;
    n_fail = 0;
    num_checks = 0;
    i_rst = 1'b1;
    i_req = 1'b0;
    i_data = '0;
    last_d = '0;
    i_use_strobe = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    check("reset code", 16'h0000, o_code);
    send(12'hFFF, 1'b0);
    send(12'h000, 1'b1);
    send(12'h801, 1'b1);
    send(12'h001, 1'b0);
    for (i = 0; i < 20; i++) begin
      send(12'($random(seed)), 1'($random(seed)));
    end
    // reset in mid-frame: host mirror clears, converter keeps old code
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_data <= 12'hA5A;
    repeat (8) @(posedge i_sys_clk);
    i_req <= 1'b0;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    check("code after reset", 16'h0000, o_code);
    check("kept code", exp_code(last_d), dev_code);
    send(12'h3C3, 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
